// *** hdl/csci_consts.svh ***
// Purpose: Offsets, field positions and reset values of the cascade
//          select, configuration and interrupt control block.
// Assumes: APB with 32-bit data; one register per aligned word.
// Notes:   Register indices are word indices; byte address = 4 * index.
//
// Summary of operation
// - CFG, ICTL and ISTAT answer only when strap ID matches select
// - Configuration cleared only by hardware reset
// - Bit 0 reports I/O supply level
// - Top cascade index maps boot block windows
// - Bit 7 mirrors interface strap, read-only
// - Six interrupt channels, numbered 0 to 5
// - Enabled channel latches activity, interrupt if masked-in
// - Disabled channel holds its status cleared
// - Mask bit gates status onto interrupt output
// - Level mode: output low until cleared
// - Edge mode: short low pulse, then high
// - Global gate opens output; pending fires immediately
// - Gate closed forces output high
// - Interrupt status register shows latched channels

`ifndef CSCI_CONSTS_SVH
`define CSCI_CONSTS_SVH

`define CSCI_IDX_USEL        14'h100A
`define CSCI_IDX_CFG         14'h100E
`define CSCI_IDX_ICTL        14'h1010
`define CSCI_IDX_ISTAT       14'h1012
`define CSCI_IDX_EVT         14'h1014
`define CSCI_IDX_EVMASK      14'h1015

`define CSCI_NCHAN           6
`define CSCI_USEL_RST        2'h0
`define CSCI_TOP_RST         2'h0
`define CSCI_ICTL_RST        16'h0000
`define CSCI_EVT_RST         2'h0

`define CSCI_CFG_SUPPLY_BIT  0
`define CSCI_CFG_TOP_LO      4
`define CSCI_CFG_TOP_HI      5
`define CSCI_CFG_STRAP_BIT   7
`define CSCI_ICTL_MASK_LO    8
`define CSCI_ICTL_MASK_HI    13
`define CSCI_ICTL_EDGE_BIT   14
`define CSCI_ICTL_GATE_BIT   15

`endif

// *** hdl/csci_irq_core.sv ***
// Purpose: Six-channel latch and active-low interrupt output generation.
// Assumes: Sources are on the same clock as this block.
// Notes:   Status is cleared only by disabling its channel.
`default_nettype none
`include "csci_consts.svh"

module csci_irq_core (
  input wire logic clk,
  input wire logic rstn,
  csci_irq_if.core bus
);
  import csci_pkg::*;

  logic [5:0] status_r;
  logic [5:0] statusNxt;
  logic [5:0] latchReq;
  logic       gatePrev_r;
  logic       irqN_r;
  logic       irqN_nxt;
  logic       gateRise;
  logic       fire;

  assign bus.status   = status_r;
  assign bus.newLatch = statusNxt & ~status_r;
  assign bus.irqN     = irqN_r;
  assign latchReq     = bus.en & bus.src;

  always_comb begin
    // Status persists until the host clears the enable bit
    statusNxt = bus.en & (status_r | bus.src);
    gateRise  = bus.gate & ~gatePrev_r;
    if (bus.edgeSel) begin
      fire = (|(bus.newLatch & bus.mask))
           | (gateRise & (|(statusNxt & bus.mask)));
    end else begin
      fire = |(statusNxt & bus.mask);
    end
    irqN_nxt = ~(bus.gate & fire);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_r   <= 6'h00;
      gatePrev_r <= 1'b0;
      irqN_r     <= 1'b1;
    end else begin
      status_r   <= statusNxt;
      gatePrev_r <= bus.gate;
      irqN_r     <= irqN_nxt;
    end
  end

  a_status_latch: assert property (@(posedge clk) disable iff (!rstn)
    (|latchReq) |=> ((status_r & $past(latchReq)) == $past(latchReq)))
    else $error("enabled source activity not latched");
  a_status_cleared: assert property (@(posedge clk) disable iff (!rstn)
    (bus.en != 6'h3F) |=> ((status_r & ~$past(bus.en)) == 6'h00))
    else $error("disabled channel status not held clear");
  a_mask_block: assert property (@(posedge clk) disable iff (!rstn)
    (!bus.edgeSel && ((statusNxt & bus.mask) == 6'h00)) |=> irqN_r)
    else $error("masked status asserted the interrupt");
  a_level_hold: assert property (@(posedge clk) disable iff (!rstn)
    (!bus.edgeSel && bus.gate && (|(statusNxt & bus.mask))) |=> !irqN_r)
    else $error("level interrupt not held low while pending");
  a_edge_return: assert property (@(posedge clk) disable iff (!rstn)
    (bus.edgeSel && !fire) |=> irqN_r)
    else $error("edge interrupt did not return high");
  a_gate_rise: assert property (@(posedge clk) disable iff (!rstn)
    (gateRise && (|(statusNxt & bus.mask))) |=> !irqN_r)
    else $error("opening gate with pending did not interrupt");
  a_gate_force: assert property (@(posedge clk) disable iff (!rstn)
    !bus.gate |=> irqN_r)
    else $error("closed gate let the interrupt assert");
  a_edge_pulse: assert property (@(posedge clk) disable iff (!rstn)
    (bus.edgeSel && bus.gate && (|(bus.newLatch & bus.mask)))
    |=> !irqN_r)
    else $error("new unmasked latch gave no edge pulse");
endmodule

`default_nettype wire

// *** hdl/csci_irq_if.sv ***
// Purpose: Carries channel controls and status between the register
//          file and the interrupt core.
// Assumes: Single clock domain.
// Notes:   Control bits are register outputs of the top.
`default_nettype none

interface csci_irq_if;
  logic [5:0] src;
  logic [5:0] en;
  logic [5:0] mask;
  logic       edgeSel;
  logic       gate;
  logic [5:0] status;
  logic [5:0] newLatch;
  logic       irqN;

  modport ctl  (output src, en, mask, edgeSel, gate,
                input  status, newLatch, irqN);
  modport core (input  src, en, mask, edgeSel, gate,
                output status, newLatch, irqN);
endinterface

`default_nettype wire

// *** hdl/csci_pkg.sv ***
// Purpose: Types shared by the cascade select and interrupt block.
// Assumes: Nothing beyond the constants header.
// Notes:   Register selector used by the APB decode.
`default_nettype none

package csci_pkg;
  typedef enum logic [2:0] {
    REG_NONE   = 3'h0,
    REG_USEL   = 3'h1,
    REG_CFG    = 3'h2,
    REG_ICTL   = 3'h3,
    REG_ISTAT  = 3'h4,
    REG_EVT    = 3'h5,
    REG_EVMASK = 3'h6
  } csci_reg_t;
endpackage

`default_nettype wire

// *** hdl/csci_top.sv ***
// Purpose: APB register file for cascade select, configuration status
//          and interrupt control, plus a system event interrupt.
// Assumes: Strap and level-detect pins are asynchronous; interrupt
//          sources come from logic on clk.
// Notes:   Each APB access takes one wait state (pready one cycle late).
`default_nettype none
`include "csci_consts.svh"

module csci_top (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  unitIdPins,
  input  wire logic        ifCfgPin,
  input  wire logic        ioSupplyDetectPin,
  input  wire logic [5:0]  irqSources,
  output logic             irqN,
  output logic             sysIrq,
  output logic [1:0]       topCascadeIndex,
  output logic             unitSelected
);
  import csci_pkg::*;

  function automatic csci_reg_t decodeAddr(input logic [15:0] a);
    csci_reg_t r;
    r = REG_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[15:2])
        `CSCI_IDX_USEL:   r = REG_USEL;
        `CSCI_IDX_CFG:    r = REG_CFG;
        `CSCI_IDX_ICTL:   r = REG_ICTL;
        `CSCI_IDX_ISTAT:  r = REG_ISTAT;
        `CSCI_IDX_EVT:    r = REG_EVT;
        `CSCI_IDX_EVMASK: r = REG_EVMASK;
        default:          r = REG_NONE;
      endcase
    end
    return r;
  endfunction

  // Registers that are switched away when another unit is selected
  function automatic logic isGated(input csci_reg_t r);
    return (r == REG_CFG) || (r == REG_ICTL) || (r == REG_ISTAT);
  endfunction

  csci_irq_if irqBus ();

  csci_irq_core u_core (
    .clk  (clk),
    .rstn (rstn),
    .bus  (irqBus)
  );

  // Two-stage synchronisers for asynchronous pins
  logic [3:0]  pinMeta_r;
  logic [3:0]  pinSync_r;
  logic [1:0]  unitIdS;
  logic        ifCfgS;
  logic        ioSupplyHighFlag;

  assign unitIdS          = pinSync_r[1:0];
  assign ifCfgS           = pinSync_r[2];
  assign ioSupplyHighFlag = pinSync_r[3];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pinMeta_r <= 4'h0;
      pinSync_r <= 4'h0;
    end else begin
      pinMeta_r <= {ioSupplyDetectPin, ifCfgPin, unitIdPins};
      pinSync_r <= pinMeta_r;
    end
  end

  logic [1:0]  unitSelectValue_r;
  logic [1:0]  unitSelectValue_nxt;
  logic [1:0]  topCascade_r;
  logic [1:0]  topCascade_nxt;
  logic [15:0] ictl_r;
  logic [15:0] ictl_nxt;
  logic [1:0]  evt_r;
  logic [1:0]  evt_nxt;
  logic [1:0]  evMask_r;
  logic [1:0]  evMask_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic        sysIrq_r;
  logic        sysIrq_nxt;
  logic        unitSel_r;
  logic        unitSel_nxt;

  csci_reg_t   rdSel;
  csci_reg_t   wrSel;
  logic        match;
  logic        acc;
  logic        commit;
  logic        refused;
  logic [31:0] rdData;
  logic [1:0]  evtSet;
  logic [1:0]  evtClr;

  assign match = (unitIdS == unitSelectValue_r);
  assign acc    = psel & penable & ~pready_r;
  assign commit = psel & penable & pready_r;
  assign rdSel  = decodeAddr(paddr);
  assign wrSel  = decodeAddr(paddr);

  assign irqBus.src     = irqSources;
  assign irqBus.en      = ictl_r[5:0];
  assign irqBus.mask    = ictl_r[`CSCI_ICTL_MASK_HI:`CSCI_ICTL_MASK_LO];
  assign irqBus.edgeSel = ictl_r[`CSCI_ICTL_EDGE_BIT];
  assign irqBus.gate    = ictl_r[`CSCI_ICTL_GATE_BIT];

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign irqN            = irqBus.irqN;
  assign sysIrq          = sysIrq_r;
  assign topCascadeIndex = topCascade_r;
  assign unitSelected    = unitSel_r;

  always_comb begin
    rdData = 32'h0000_0000;
    case (rdSel)
      REG_USEL:   rdData = {30'h0, unitSelectValue_r};
      REG_CFG:    rdData = {24'h0, ifCfgS, 1'b0, topCascade_r,
                            3'h0, ioSupplyHighFlag};
      REG_ICTL:   rdData = {16'h0, ictl_r};
      REG_ISTAT:  rdData = {26'h0, irqBus.status};
      REG_EVT:    rdData = {30'h0, evt_r};
      REG_EVMASK: rdData = {30'h0, evMask_r};
      default:    rdData = 32'h0000_0000;
    endcase
    // A non-selected unit reads zero from, and ignores writes to, CFG, ICTL and ISTAT
    if (isGated(rdSel) && !match) begin
      rdData = 32'h0000_0000;
    end
  end

  always_comb begin
    unitSelectValue_nxt = unitSelectValue_r;
    topCascade_nxt      = topCascade_r;
    ictl_nxt            = ictl_r;
    evMask_nxt          = evMask_r;
    prdata_nxt          = prdata_r;
    pready_nxt          = acc;
    pslverr_nxt         = acc & (rdSel == REG_NONE);
    refused             = commit & isGated(wrSel) & ~match;
    evtSet              = {refused, |irqBus.newLatch};
    evtClr              = 2'h0;
    if (acc && !pwrite) begin
      prdata_nxt = rdData;
    end
    if (commit && pwrite && pstrb[0] && !refused) begin
      case (wrSel)
        // Select is written by every cascaded unit so it can move
        REG_USEL:   unitSelectValue_nxt = pwdata[1:0];
        REG_CFG:    topCascade_nxt =
                      pwdata[`CSCI_CFG_TOP_HI:`CSCI_CFG_TOP_LO];
        REG_ICTL:   ictl_nxt[5:0] = pwdata[5:0];
        REG_EVMASK: evMask_nxt = pwdata[1:0];
        default:    ;
      endcase
    end
    if (commit && pwrite && pstrb[1] && !refused
        && (wrSel == REG_ICTL)) begin
      ictl_nxt[15:8] = pwdata[15:8];
    end
    if (commit && !pwrite && (wrSel == REG_EVT)) begin
      evtClr = 2'h3;
    end
    // A new event in the clearing read cycle survives the clear
    evt_nxt     = (evt_r & ~evtClr) | evtSet;
    sysIrq_nxt  = |(evt_nxt & evMask_nxt);
    unitSel_nxt = match;
  end

  // Only hardware reset touches configuration state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      unitSelectValue_r <= `CSCI_USEL_RST;
      topCascade_r      <= `CSCI_TOP_RST;
      ictl_r            <= `CSCI_ICTL_RST;
      evt_r             <= `CSCI_EVT_RST;
      evMask_r          <= 2'h0;
      prdata_r          <= 32'h0000_0000;
      pready_r          <= 1'b0;
      pslverr_r         <= 1'b0;
      sysIrq_r          <= 1'b0;
      unitSel_r         <= 1'b0;
    end else begin
      unitSelectValue_r <= unitSelectValue_nxt;
      topCascade_r      <= topCascade_nxt;
      ictl_r            <= ictl_nxt;
      evt_r             <= evt_nxt;
      evMask_r          <= evMask_nxt;
      prdata_r          <= prdata_nxt;
      pready_r          <= pready_nxt;
      pslverr_r         <= pslverr_nxt;
      sysIrq_r          <= sysIrq_nxt;
      unitSel_r         <= unitSel_nxt;
    end
  end

  logic cfgRead;
  logic istatRead;
  assign cfgRead   = acc && !pwrite && (rdSel == REG_CFG) && match;
  assign istatRead = acc && !pwrite && (rdSel == REG_ISTAT) && match;

  a_usel_gate: assert property (@(posedge clk) disable iff (!rstn)
    (commit && pwrite && isGated(wrSel) && !match) |=> $stable(ictl_r)
      && $stable(topCascade_r))
    else $error("unselected unit accepted a register write");
  a_cfg_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(commit && pwrite && (wrSel == REG_CFG)) |=> $stable(topCascade_r))
    else $error("top cascade index changed without a write");
  a_supply_bit: assert property (@(posedge clk) disable iff (!rstn)
    cfgRead |=> pready_r
      && (prdata_r[`CSCI_CFG_SUPPLY_BIT] == $past(ioSupplyHighFlag)))
    else $error("supply flag read wrong");
  a_strap_mirror: assert property (@(posedge clk) disable iff (!rstn)
    cfgRead |=> (prdata_r[`CSCI_CFG_STRAP_BIT] == $past(ifCfgS)))
    else $error("interface strap not mirrored");
  a_istat_read: assert property (@(posedge clk) disable iff (!rstn)
    istatRead |=> (prdata_r[5:0] == $past(irqBus.status)))
    else $error("interrupt status read wrong");
  a_sys_irq_level: assert property (@(posedge clk) disable iff (!rstn)
    (evt_r & evMask_r) != 2'h0 |-> sysIrq_r)
    else $error("system interrupt low with unmasked event");
  a_ready_answer: assert property (@(posedge clk) disable iff (!rstn)
    acc |=> pready_r)
    else $error("access phase got no ready");
  a_ready_single: assert property (@(posedge clk) disable iff (!rstn)
    pready_r |=> !pready_r)
    else $error("ready stood for more than one cycle");
  a_unmapped_err: assert property (@(posedge clk) disable iff (!rstn)
    (acc && (rdSel == REG_NONE)) |=> (pready_r && pslverr_r))
    else $error("unmapped access gave no error");
  a_err_ready: assert property (@(posedge clk) disable iff (!rstn)
    pslverr_r |-> pready_r)
    else $error("error response without ready");
  a_unsel_read: assert property (@(posedge clk) disable iff (!rstn)
    (acc && !pwrite && isGated(rdSel) && !match)
    |=> (prdata_r == 32'h0000_0000))
    else $error("unselected unit returned register data");
  a_refused_event: assert property (@(posedge clk) disable iff (!rstn)
    refused |=> evt_r[1])
    else $error("refused access did not raise its event");
  a_usel_write: assert property (@(posedge clk) disable iff (!rstn)
    (commit && pwrite && pstrb[0] && (wrSel == REG_USEL))
    |=> ({30'h0, unitSelectValue_r} == ($past(pwdata) & 32'h0000_0003)))
    else $error("unit select write lost");
  a_top_write: assert property (@(posedge clk) disable iff (!rstn)
    (commit && pwrite && pstrb[0] && (wrSel == REG_CFG) && match)
    |=> ({26'h0, topCascade_r, 4'h0} == ($past(pwdata) & 32'h0000_0030)))
    else $error("top cascade index write lost");
  a_enable_write: assert property (@(posedge clk) disable iff (!rstn)
    (commit && pwrite && pstrb[0] && (wrSel == REG_ICTL) && match)
    |=> ({26'h0, ictl_r[5:0]} == ($past(pwdata) & 32'h0000_003F)))
    else $error("channel enable write lost");
  a_evt_clear: assert property (@(posedge clk) disable iff (!rstn)
    (commit && !pwrite && (wrSel == REG_EVT) && (evtSet == 2'h0))
    |=> (evt_r == 2'h0))
    else $error("event read did not clear");
  a_evt_sticky: assert property (@(posedge clk) disable iff (!rstn)
    ((evt_r != 2'h0) && !(commit && !pwrite && (wrSel == REG_EVT)))
    |=> ((evt_r & $past(evt_r)) == $past(evt_r)))
    else $error("event bit dropped without a read");
endmodule

`default_nettype wire

// *** verification/cascade_select_config_irq_tb_top.sv ***
// Purpose: Self-checking bench for cascade select, configuration and
//          interrupt control.
// Assumes: Straps are synchronised within three clocks.
// Notes:   Each scenario is one task; the host model drives APB.
`default_nettype none
`include "csci_consts.svh"

module cascade_select_config_irq_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  unitIdPins;
  logic        ifCfgPin;
  logic        ioSupplyDetectPin;
  logic [5:0]  irqSources;
  logic        irqN;
  logic        sysIrq;
  logic [1:0]  topCascadeIndex;
  logic        unitSelected;
  logic [31:0] rd;
  logic        er;
  int          n_fail;
  int          comparisons;

  csci_top i_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .unitIdPins(unitIdPins), .ifCfgPin(ifCfgPin),
    .ioSupplyDetectPin(ioSupplyDetectPin), .irqSources(irqSources),
    .irqN(irqN), .sysIrq(sysIrq), .topCascadeIndex(topCascadeIndex),
    .unitSelected(unitSelected));

  csci_host_model i_host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({31'b0, got}, {31'b0, exp});
  endtask

  task automatic wr(input logic [13:0] i, input logic [31:0] d);
    i_host.xfer(1'b1, i, d, rd, er);
  endtask

  task automatic rdc(input logic [13:0] i, input logic [31:0] e);
    i_host.xfer(1'b0, i, 32'h0000_0000, rd, er);
    chk(rd, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic src(input logic [5:0] v);
    @(posedge clk);
    irqSources <= v;
  endtask

  task automatic t_reset;
    chkb(irqN, 1'b1);
    rdc(`CSCI_IDX_USEL, 32'h0000_0000);
    rdc(`CSCI_IDX_ICTL, 32'h0000_0000);
    rdc(`CSCI_IDX_ISTAT, 32'h0000_0000);
    rdc(`CSCI_IDX_CFG, 32'h0000_0080);
    @(posedge clk);
    ifCfgPin <= 1'b0;
    ioSupplyDetectPin <= 1'b1;
    cyc(3);
    rdc(`CSCI_IDX_CFG, 32'h0000_0001);
    $display("test reset done");
  endtask

  // Refused accesses must also raise the refused-access event
  task automatic t_select;
    wr(`CSCI_IDX_EVMASK, 32'h0000_0002);
    rdc(`CSCI_IDX_EVT, 32'h0000_0000);
    @(posedge clk);
    unitIdPins <= 2'h2;
    cyc(3);
    chkb(unitSelected, 1'b0);
    rdc(`CSCI_IDX_CFG, 32'h0000_0000);
    wr(`CSCI_IDX_ICTL, 32'h0000_FFFF);
    cyc(1);
    chkb(sysIrq, 1'b1);
    wr(`CSCI_IDX_USEL, 32'h0000_0002);
    cyc(2);
    chkb(unitSelected, 1'b1);
    rdc(`CSCI_IDX_ICTL, 32'h0000_0000);
    rdc(`CSCI_IDX_EVT, 32'h0000_0002);
    cyc(1);
    chkb(sysIrq, 1'b0);
    i_host.xfer(1'b0, 14'h1001, 32'h0000_0000, rd, er);
    chkb(er, 1'b1);
    chk(rd, 32'h0000_0000);
    $display("test select done");
  endtask

  task automatic t_config;
    wr(`CSCI_IDX_CFG, 32'h0000_00FF);
    rdc(`CSCI_IDX_CFG, 32'h0000_0031);
    chk({30'b0, topCascadeIndex}, 32'h0000_0003);
    $display("test config done");
  endtask

  task automatic t_level;
    wr(`CSCI_IDX_ICTL, 32'h0000_8103);
    src(6'h02);
    cyc(2);
    chkb(irqN, 1'b1);
    rdc(`CSCI_IDX_ISTAT, 32'h0000_0002);
    src(6'h01);
    src(6'h00);
    cyc(2);
    chkb(irqN, 1'b0);
    rdc(`CSCI_IDX_ISTAT, 32'h0000_0003);
    wr(`CSCI_IDX_ICTL, 32'h0000_0103);
    cyc(2);
    chkb(irqN, 1'b1);
    wr(`CSCI_IDX_ICTL, 32'h0000_8103);
    cyc(2);
    chkb(irqN, 1'b0);
    wr(`CSCI_IDX_ICTL, 32'h0000_8102);
    cyc(2);
    chkb(irqN, 1'b1);
    rdc(`CSCI_IDX_ISTAT, 32'h0000_0002);
    wr(`CSCI_IDX_ICTL, 32'h0000_8103);
    rdc(`CSCI_IDX_ISTAT, 32'h0000_0002);
    wr(`CSCI_IDX_ICTL, 32'h0000_0000);
    $display("test level done");
  endtask

  // Source held high: only the first latch may pulse the output
  task automatic t_edge;
    int lows;
    for (int ch = 0; ch < `CSCI_NCHAN; ch++) begin
      wr(`CSCI_IDX_ICTL, 32'h0000_C000 | (32'h1 << (8 + ch)) | (32'h1 << ch));
      src(6'h01 << ch);
      lows = 0;
      repeat (8) begin
        @(posedge clk);
        #1;
        if (irqN === 1'b0) lows++;
      end
      chk(32'(lows), 32'h0000_0001);
      wr(`CSCI_IDX_ICTL, 32'h0000_0000);
      src(6'h00);
    end
    $display("test edge done");
  endtask

  task automatic print_verdict;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #25000;
    n_fail++;
    print_verdict();
  end

  initial begin
    n_fail = 0;
    comparisons = 0;
    rstn = 1'b0;
    unitIdPins = 2'h0;
    ifCfgPin = 1'b1;
    ioSupplyDetectPin = 1'b0;
    irqSources = 6'h00;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    cyc(3);
    t_reset();
    t_select();
    t_config();
    t_level();
    t_edge();
    print_verdict();
  end
endmodule

`default_nettype wire

// *** verification/csci_host_model.sv ***
// Purpose: Host processor model speaking APB to the register block.
// Assumes: One clock; the block answers with pready after wait states.
// Notes:   Address and data are inverted on release so a stale bus
//          value can never pass for a live one.
`default_nettype none

module csci_host_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [15:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 100ps;

  assign pstrb = 4'hF;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 16'h0000;
    pwdata  = 32'h0000_0000;
  end

  // No cycle limit here: only the bench watchdog may end a hung access
  task automatic xfer(input logic wr, input logic [13:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~{idx, 2'b00};
    pwdata  <= ~wd;
  endtask
endmodule

`default_nettype wire
